// ==== include/sei_pkg.sv ====
// Purpose: Shared constants for the slot event interrupt enable block
// Assumes: Byte-addressed register port, 5-bit address, 8-bit data
// Notes: Event bit positions 0..5 double as the pin group index

package sei_pkg;

   localparam int SLOTS = 4;
   localparam int DW = 8;
   localparam int AW = 5;
   localparam int PIN_GROUPS = 6;
   localparam int SYNC_W = SLOTS * PIN_GROUPS;

   // Per-slot register offsets, index 0 is slot 0
   localparam logic [SLOTS-1:0][AW-1:0] STATUS_OFS =
      {5'h1E, 5'h16, 5'h0E, 5'h06};
   localparam logic [SLOTS-1:0][AW-1:0] ENABLE_OFS =
      {5'h1F, 5'h17, 5'h0F, 5'h07};

   localparam logic [DW-1:0] ENABLE_RESET = 8'h00;
   localparam logic [DW-1:0] STATUS_RESET = 8'h00;
   localparam logic [DW-1:0] ENABLE_MASK = 8'h7F;
   localparam logic [DW-1:0] STATUS_MASK = 8'h7F;
   localparam logic [DW-1:0] READ_IDLE = 8'h00;

   // Event bits; bits 0..5 also select the pin group
   localparam int BIT_CARD_A = 0;
   localparam int BIT_CARD_B = 1;
   localparam int BIT_MECH_A = 2;
   localparam int BIT_MECH_B = 3;
   localparam int BIT_POWER_FAIL = 4;
   localparam int BIT_POWER_OK = 5;
   localparam int BIT_BUS = 6;
   localparam int BIT_RESERVED_BIT = 7;

   function automatic logic sei_hit(input logic [AW-1:0] addr,
                                    input logic [AW-1:0] ofs);
      sei_hit = (addr == ofs);
   endfunction

endpackage

// ==== testbench/sei_slot_model.sv ====
// Purpose: Slot card, power and detect pins seen by the block
// Assumes: One pin toggles per request, 3 ns after the clock edge
// Notes: Pins move off the clock edge, as real slot pins do

`timescale 1ns/1ns

module sei_slot_model (
   // Clock
   input wire logic mclk,
   // Toggle request
   input wire logic go,
   input wire logic [4:0] pin_sel,
   // Slot pins, group index times four plus slot
   output logic [23:0] pins
);
   initial pins = 24'h000000;
   always @(posedge mclk) begin
      if (go) begin
         pins[pin_sel] <= #3 ~pins[pin_sel];
      end
   end
endmodule

// ==== testbench/slot_event_irq_enable_bench.sv ====
// Purpose: Self-checking bench for the slot event interrupt block
// Assumes: Slot pins come from the slot model
// Notes: Open-drain wire has a pull-up

`timescale 1ns/1ns

module slot_event_irq_enable_bench;
   import sei_pkg::*;
   typedef struct packed {
      logic [1:0] slot;
      logic [2:0] grp;
      logic [DW-1:0] exp_st;
   } sei_row_s;
   logic mclk, rst_b, reg_wr_en, reg_rd_en, go, irq_out, irq_oe_b;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata;
   logic [SLOTS-1:0] sw_on;
   logic [4:0] pin_sel;
   logic [23:0] pins;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   wire irq_wire = irq_oe_b ? 1'b1 : irq_out;
   sei_row_s rows [8] = '{'{2'h0, 3'h0, 8'h01}, '{2'h1, 3'h1, 8'h02},
      '{2'h2, 3'h2, 8'h04}, '{2'h3, 3'h3, 8'h08}, '{2'h0, 3'h4, 8'h10},
      '{2'h0, 3'h4, 8'h00}, '{2'h1, 3'h5, 8'h20}, '{2'h1, 3'h5, 8'h20}};

   sei_top dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .slot_switch_on_out(sw_on),
      .slot_power_ok_in(pins[23:20]), .slot_power_fail_in(pins[19:16]),
      .mech_sense_a_in(pins[11:8]), .mech_sense_b_in(pins[15:12]),
      .card_here_a_in(pins[3:0]), .card_here_b_in(pins[7:4]),
      .hot_plug_irq_in(irq_wire), .hot_plug_irq_out(irq_out),
      .hot_plug_irq_oe_b(irq_oe_b));
   sei_slot_model slots (.mclk(mclk), .go(go), .pin_sel(pin_sel),
      .pins(pins));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total = err_total + 1;
         report_and_stop();
      end
   end

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      @(posedge mclk);
      #1 chk(reg_rdata, exp);
   endtask

   task automatic tog(input logic [4:0] sel);
      @(posedge mclk);
      pin_sel <= sel;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask

   initial begin
      rst_b = 1'b0;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      sw_on = 4'h0;
      go = 1'b0;
      pin_sel = 5'h00;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      for (int s = 0; s < SLOTS; s++) begin
         rd(STATUS_OFS[s], 8'h00);
         rd(ENABLE_OFS[s], 8'h00);
         wr(ENABLE_OFS[s], 8'hFF);
         rd(ENABLE_OFS[s], 8'h7F);
         wr(ENABLE_OFS[s], 8'h00);
      end
      wr(5'h05, 8'hFF);
      rd(5'h05, 8'h00);
      chk({7'h00, irq_oe_b}, 8'h01);
      $display("test registers done");
      foreach (rows[i]) begin
         wr(ENABLE_OFS[rows[i].slot], 8'h01 << rows[i].grp);
         tog({rows[i].grp, rows[i].slot});
         rd(STATUS_OFS[rows[i].slot], rows[i].exp_st);
         chk({7'h00, irq_oe_b}, {7'h00, rows[i].exp_st == 8'h00});
         wr(STATUS_OFS[rows[i].slot], rows[i].exp_st);
         repeat (2) @(posedge mclk);
         #1 chk({7'h00, irq_oe_b}, 8'h01);
         rd(STATUS_OFS[rows[i].slot], 8'h00);
         wr(ENABLE_OFS[rows[i].slot], 8'h00);
      end
      $display("test events done");
      tog({3'h1, 2'h2});
      #1 chk({7'h00, irq_oe_b}, 8'h01);
      wr(ENABLE_OFS[2], 8'h02);
      repeat (2) @(posedge mclk);
      #1 chk({7'h00, irq_oe_b}, 8'h00);
      chk({7'h00, irq_out}, 8'h00);
      wr(STATUS_OFS[2], 8'h00);
      rd(STATUS_OFS[2], 8'h02);
      wr(STATUS_OFS[2], 8'h02);
      wr(ENABLE_OFS[2], 8'h00);
      $display("test masking done");
      wr(ENABLE_OFS[3], 8'h40);
      sw_on <= 4'h8;
      repeat (4) @(posedge mclk);
      rd(STATUS_OFS[3], 8'h00);
      sw_on <= 4'h0;
      repeat (4) @(posedge mclk);
      rd(STATUS_OFS[3], 8'h40);
      chk({7'h00, irq_oe_b}, 8'h00);
      wr(STATUS_OFS[3], 8'hFF);
      rd(STATUS_OFS[3], 8'h00);
      $display("test bus switch done");
      wr(ENABLE_OFS[1], 8'h3C);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      rd(ENABLE_OFS[1], 8'h00);
      rd(ENABLE_OFS[3], 8'h00);
      chk({7'h00, irq_oe_b}, 8'h01);
      chk({7'h00, irq_out}, 8'h00);
      $display("test second reset done");
      report_and_stop();
   end
endmodule

// ==== verilog/sei_sync.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to mclk
// Notes: The first clock after reset only loads the level, it gives no pulse

`timescale 1ns/1ns

module sei_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Pins
   input wire logic [W-1:0] pin_in,
   // Filtered level and change pulse
   output logic [W-1:0] stable,
   output logic [W-1:0] chg
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] seen;
      logic [W-1:0] chg;
   } sei_sync_s;

   sei_sync_s state_r;
   sei_sync_s state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.s1 = pin_in;
      state_nxt.s2 = state_r.s1;
      state_nxt.s3 = state_r.s2;
      state_nxt.chg = '0;
      for (int i = 0; i < W; i++) begin
         if (state_r.s2[i] == state_r.s3[i]) begin
            state_nxt.lvl[i] = state_r.s3[i];
            state_nxt.seen[i] = 1'b1;
            state_nxt.chg[i] = state_r.seen[i] &
                               (state_r.s3[i] != state_r.lvl[i]);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign stable = state_r.lvl;
   assign chg = state_r.chg;

endmodule

// ==== verilog/sei_top.sv ====
// Purpose: Per-slot event status, event enable and shared interrupt
// Assumes: Register port on mclk; slot pins asynchronous to mclk
// Notes: Interrupt pin is open drain, driven low while an enabled
//        status bit is set
//
// What this block does
// R1 - Enable bit 7 is reserved, reads as zero and ignores writes.
// R2 - Slot 0..3 enable registers sit at 07h, 0Fh, 17h and 1Fh.
// R3 - Enable bit 6 raises the interrupt when the bus switch output falls.
// R4 - Enable bit 5 raises the interrupt on any power-good level change.
// R5 - Enable bit 4 raises the interrupt when power fault becomes asserted.
// R6 - Enable bits 3 and 2 cover level changes of mechanical sense b and a.
// R7 - Enable bits 1 and 0 cover level changes of card present b and a.
// R8 - Enable bits 6..0 are read/write and the register resets to 00h.
// R9 - Events go to one open-drain interrupt and latch in a status register.
// R10 - A status bit latches on its event and clears only by writing 1.
// R11 - Status registers sit at 06h, 0Eh, 16h, 1Eh and reset to 00h.
// R12 - The interrupt is pulled low while any enabled status bit is set.

`timescale 1ns/1ns

module sei_top
   import sei_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [DW-1:0] reg_rdata,
   // Bus switch level from the connection sequencer, per slot
   input wire logic [SLOTS-1:0] slot_switch_on_out,
   // Slot pins
   input wire logic [SLOTS-1:0] slot_power_ok_in,
   input wire logic [SLOTS-1:0] slot_power_fail_in,
   input wire logic [SLOTS-1:0] mech_sense_a_in,
   input wire logic [SLOTS-1:0] mech_sense_b_in,
   input wire logic [SLOTS-1:0] card_here_a_in,
   input wire logic [SLOTS-1:0] card_here_b_in,
   // Open-drain interrupt
   input wire logic hot_plug_irq_in,
   output logic hot_plug_irq_out,
   output logic hot_plug_irq_oe_b
);

   typedef struct packed {
      logic [SLOTS-1:0][DW-1:0] en;
      logic [SLOTS-1:0][DW-1:0] st;
      logic [SLOTS-1:0] bus_prev;
      logic [DW-1:0] rdata;
      logic irq_oe_b;
      logic irq_out;
   } sei_state_s;

   sei_state_s state_r;
   sei_state_s state_nxt;
   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] stable;
   logic [SYNC_W-1:0] chg;
   logic [DW-1:0] clr;
   logic [DW-1:0] ev;
   logic pend;

   // Group g of slot s sits at g*SLOTS+s; group order follows event bits
   assign pins = {slot_power_ok_in, slot_power_fail_in, mech_sense_b_in,
                  mech_sense_a_in, card_here_b_in, card_here_a_in};

   sei_sync #(
      .W(SYNC_W)
   ) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin_in(pins),
      .stable(stable),
      .chg(chg)
   );

   always_comb begin
      state_nxt = state_r;
      clr = '0;
      ev = '0;
      pend = 1'b0;
      for (int s = 0; s < SLOTS; s++) begin
         if (reg_wr_en && sei_hit(reg_addr, ENABLE_OFS[s])) begin // R2
            state_nxt.en[s] = reg_wdata & ENABLE_MASK; // R1 R8
         end
         clr = '0;
         if (reg_wr_en && sei_hit(reg_addr, STATUS_OFS[s])) begin // R11
            clr = reg_wdata;
         end
         ev = '0;
         for (int b = 0; b < PIN_GROUPS; b++) begin
            ev[b] = chg[b*SLOTS+s]; // R4 R6 R7
         end
         // Only the asserting edge of power fault counts
         ev[BIT_POWER_FAIL] = chg[BIT_POWER_FAIL*SLOTS+s] &
                              stable[BIT_POWER_FAIL*SLOTS+s]; // R5
         ev[BIT_BUS] = state_r.bus_prev[s] & ~slot_switch_on_out[s]; // R3
         // A new event wins over a clear in the same cycle
         state_nxt.st[s] = ((state_r.st[s] & ~clr) | ev) & STATUS_MASK; // R10
         state_nxt.bus_prev[s] = slot_switch_on_out[s];
         pend = pend | (|(state_r.st[s] & state_r.en[s])); // R12
      end
      state_nxt.irq_oe_b = ~pend; // R9 R12
      state_nxt.irq_out = 1'b0; // R9
      if (reg_rd_en) begin
         state_nxt.rdata = READ_IDLE;
         for (int s = 0; s < SLOTS; s++) begin
            if (sei_hit(reg_addr, ENABLE_OFS[s])) begin // R2
               state_nxt.rdata = state_r.en[s];
            end
            if (sei_hit(reg_addr, STATUS_OFS[s])) begin // R11
               state_nxt.rdata = state_r.st[s];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r.en <= {SLOTS{ENABLE_RESET}}; // R8
         state_r.st <= {SLOTS{STATUS_RESET}}; // R11
         state_r.bus_prev <= '0;
         state_r.rdata <= READ_IDLE;
         state_r.irq_oe_b <= 1'b1;
         state_r.irq_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata = state_r.rdata;
   assign hot_plug_irq_out = state_r.irq_out;
   assign hot_plug_irq_oe_b = state_r.irq_oe_b;

   // Checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_wr_en0;
      reg_wr_en && sei_hit(reg_addr, ENABLE_OFS[0]);
   endsequence

   sequence s_rd_en0;
      reg_rd_en && !reg_wr_en && sei_hit(reg_addr, ENABLE_OFS[0]);
   endsequence

   sequence s_clr_mech_a0;
      reg_wr_en && sei_hit(reg_addr, STATUS_OFS[0]) &&
      reg_wdata[BIT_MECH_A] && !chg[BIT_MECH_A*SLOTS];
   endsequence

   AST_RESERVED_BIT_READ: assert property ( // R1
      reg_rd_en |=> !state_r.rdata[BIT_RESERVED_BIT])
      else $error("reserved bit read back as one");

   AST_EN_RW: assert property ( // R8
      s_wr_en0 ##1 s_rd_en0 |=>
      state_r.rdata == ($past(reg_wdata, 2) & ENABLE_MASK))
      else $error("slot 0 enable did not read back as written");

   AST_EN_SLOT3: assert property ( // R2
      reg_wr_en && sei_hit(reg_addr, ENABLE_OFS[3]) |=>
      state_r.en[3] == ($past(reg_wdata) & ENABLE_MASK))
      else $error("slot 3 enable not written at its offset");

   AST_BUS_EVT: assert property ( // R3
      $fell(slot_switch_on_out[0]) |=> state_r.st[0][BIT_BUS])
      else $error("bus switch fall did not set status");

   AST_PWROK_EVT: assert property ( // R4
      chg[BIT_POWER_OK*SLOTS+1] |=> state_r.st[1][BIT_POWER_OK])
      else $error("power good change did not set status");

   AST_PFAIL_EVT: assert property ( // R5
      chg[BIT_POWER_FAIL*SLOTS+2] && stable[BIT_POWER_FAIL*SLOTS+2]
      |=> state_r.st[2][BIT_POWER_FAIL])
      else $error("power fault assertion did not set status");

   AST_MECH_EVT: assert property ( // R6
      chg[BIT_MECH_B*SLOTS+3] |=> state_r.st[3][BIT_MECH_B])
      else $error("mechanical sense change did not set status");

   AST_CARD_EVT: assert property ( // R7
      chg[BIT_CARD_A*SLOTS] |=> state_r.st[0][BIT_CARD_A])
      else $error("card present change did not set status");

   AST_ST_HOLD: assert property ( // R10
      state_r.st[1][BIT_MECH_A] && !reg_wr_en |=>
      state_r.st[1][BIT_MECH_A])
      else $error("status bit dropped without a clear");

   AST_ST_CLEAR: assert property ( // R10
      s_clr_mech_a0 |=> !state_r.st[0][BIT_MECH_A])
      else $error("write of one did not clear status");

   AST_ST_READ: assert property ( // R11
      reg_rd_en && sei_hit(reg_addr, STATUS_OFS[0]) |=>
      state_r.rdata == $past(state_r.st[0]))
      else $error("status read returned wrong value");

   AST_IRQ_ON: assert property ( // R12
      pend |=> !hot_plug_irq_oe_b && !hot_plug_irq_out)
      else $error("interrupt not driven low while pending");

   AST_IRQ_OFF: assert property ( // R9
      !pend |=> hot_plug_irq_oe_b)
      else $error("interrupt driven without enabled status");

endmodule
